//--- hw/skew_strap_ctrl.v
// Behaviour
// - each synthesizer owns four output dividers, each enabled on its own.
// - dividers 0 and 1 feed differential outputs, 2 and 3 single-ended ones.
// - fine phase is shared by all four outputs; coarse phase is per single-ended output.
// - fine phase is an 8-bit advance in 1/256 synthesizer periods for all four outputs.
// - coarse phase moves a single-ended output in whole synthesizer periods.
// - nine references are single-ended or differential, two more single-ended only.
// - every reference resets single-ended until software sets its differential bit.
// - internal system clocks all derive from the master clock input.
// - reference monitoring takes the master clock frequency as its zero-offset point.
// - the master clock strap is taken from gpio 1:0 after reset release, held 125 ms.
// - strap 00 is 24.576 MHz, 01 is 49.152 MHz, 10 is 20 MHz, 11 is reserved.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "skew_strap_regs.vh"
`default_nettype none

module skew_strap_ctrl #(
    parameter NUM_SYNTH   = 4,
    parameter COARSE_W    = 6,
    parameter HOLD_CYC    = `STRAP_HOLD_CYC
) (
    input  wire                      i_clk,          // 40 mhz system clock
    input  wire                      i_reset_n,      // power-on reset, active low
    input  wire [1:0]                i_gpio_strap,   // gpio 1:0 strap pins
    input  wire [7:0]                i_awaddr,       // write address
    input  wire                      i_awvalid,      // write address valid
    output reg                       o_awready,      // write address ready
    input  wire [31:0]               i_wdata,        // write data
    input  wire [3:0]                i_wstrb,        // write byte strobes
    input  wire                      i_wvalid,       // write data valid
    output reg                       o_wready,       // write data ready
    output reg  [1:0]                o_bresp,        // write response
    output reg                       o_bvalid,       // write response valid
    input  wire                      i_bready,       // write response ready
    input  wire [7:0]                i_araddr,       // read address
    input  wire                      i_arvalid,      // read address valid
    output reg                       o_arready,      // read address ready
    output reg  [31:0]               o_rdata,        // read data
    output reg  [1:0]                o_rresp,        // read response
    output reg                       o_rvalid,       // read data valid
    input  wire                      i_rready,       // read data ready
    output reg  [NUM_SYNTH*8-1:0]    o_fine_phase,   // per synth fine advance
    output reg  [NUM_SYNTH*2*COARSE_W-1:0] o_coarse_phase, // per se output steps
    output reg  [NUM_SYNTH*4-1:0]    o_div_en,       // per divider enables
    output reg  [8:0]                o_ref_diff,     // ref 0..8 differential mode
    output reg  [1:0]                o_mclk_sel,     // captured master clock code
    output reg                       o_mclk_valid,   // strap capture done
    output reg  [31:0]               o_mclk_hz       // zero-offset reference freq
);

    //--------------------------------------------------------------------
    // register storage
    //--------------------------------------------------------------------
    reg  [31:0] fine_q;
    reg  [31:0] coarse_raw_q;
    reg  [31:0] trim_q;
    wire [NUM_SYNTH*2*COARSE_W-1:0] coarse_cl;

    // one clamp per single-ended output, raw field is 4 bits each
    genvar g;
    generate
        for (g = 0; g < NUM_SYNTH*2; g = g + 1) begin : g_clamp
            coarse_clamp #(
                .IN_W  (4),
                .OUT_W (COARSE_W)
            ) u_clamp (
                .i_raw   (coarse_raw_q[g*4 +: 4]),
                .o_steps (coarse_cl[g*COARSE_W +: COARSE_W])
            );
        end
    endgenerate

    //--------------------------------------------------------------------
    // strap capture
    //--------------------------------------------------------------------
    localparam ST_WAIT = 3'b001;
    localparam ST_HOLD = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0]  st_q;
    reg [31:0] hold_cnt_q;

    // sample on the first edge after release, then wait out the hold
    // window; pins are free gpio afterwards and never looked at again
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q         <= ST_WAIT;
            hold_cnt_q   <= 32'h0000_0000;
            o_mclk_sel   <= `STRAP_24M576;
            o_mclk_valid <= 1'b0;
            o_mclk_hz    <= `MCLK_HZ_24M576;
        end else begin
            case (st_q)
                ST_WAIT: begin
                    o_mclk_sel <= i_gpio_strap;
                    case (i_gpio_strap)
                        `STRAP_24M576: o_mclk_hz <= `MCLK_HZ_24M576;
                        `STRAP_49M152: o_mclk_hz <= `MCLK_HZ_49M152;
                        `STRAP_20M:    o_mclk_hz <= `MCLK_HZ_20M;
                        default:       o_mclk_hz <= 32'h0000_0000; // reserved
                    endcase
                    hold_cnt_q <= 32'h0000_0000;
                    st_q       <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (hold_cnt_q >= HOLD_CYC - 1) begin
                        o_mclk_valid <= 1'b1;
                        st_q         <= ST_DONE;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
                    end
                end
                ST_DONE: begin
                    st_q <= ST_DONE;
                end
                default: begin
                    st_q <= ST_DONE;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------
    // axi4-lite write channel
    //--------------------------------------------------------------------
    reg        aw_have_q;
    reg        w_have_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    wire       do_write;
    wire       wr_hit;

    assign do_write = aw_have_q && w_have_q && !o_bvalid;
    assign wr_hit   = (awaddr_q == `REG_FINE_PHASE) || (awaddr_q == `REG_COARSE_PHASE) ||
                      (awaddr_q == `REG_REF_CONFIG) || (awaddr_q == `REG_DIV_ENABLE) ||
                      (awaddr_q == `REG_MCLK_TRIM);

    // merge strobed bytes into a stored word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  stb;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (stb[k]) begin
                    merge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction

    // address and data accepted in either order, one write at a time
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_have_q      <= 1'b0;
            w_have_q       <= 1'b0;
            awaddr_q       <= 8'h00;
            wdata_q        <= 32'h0000_0000;
            wstrb_q        <= 4'h0;
            o_awready      <= 1'b0;
            o_wready       <= 1'b0;
            o_bvalid       <= 1'b0;
            o_bresp        <= `RESP_OKAY;
            fine_q         <= `RST_FINE_PHASE;
            coarse_raw_q   <= `RST_COARSE_PHASE;
            trim_q         <= `RST_MCLK_TRIM;
            o_ref_diff     <= `RST_REF_CONFIG;
            o_div_en       <= {NUM_SYNTH*4{1'b0}};
        end else begin
            o_awready <= !aw_have_q && !o_awready && i_awvalid && !o_bvalid;
            o_wready  <= !w_have_q && !o_wready && i_wvalid && !o_bvalid;
            if (o_awready && i_awvalid) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_awaddr;
            end
            if (o_wready && i_wvalid) begin
                w_have_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                case (awaddr_q)
                    `REG_FINE_PHASE:   fine_q <= merge(fine_q, wdata_q, wstrb_q);
                    `REG_COARSE_PHASE: coarse_raw_q <= merge(coarse_raw_q, wdata_q, wstrb_q);
                    `REG_REF_CONFIG: begin
                        if (wstrb_q[0]) o_ref_diff[7:0] <= wdata_q[7:0];
                        if (wstrb_q[1]) o_ref_diff[8]   <= wdata_q[8];
                    end
                    `REG_DIV_ENABLE: begin
                        if (wstrb_q[0]) o_div_en[7:0]  <= wdata_q[7:0];
                        if (wstrb_q[1]) o_div_en[15:8] <= wdata_q[15:8];
                    end
                    `REG_MCLK_TRIM: trim_q <= merge(trim_q, wdata_q, wstrb_q);
                    default: ;
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------------
    // phase outputs, registered
    //--------------------------------------------------------------------
    // fine byte per synth shared by its four outputs, coarse per se output
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fine_phase   <= {NUM_SYNTH*8{1'b0}};
            o_coarse_phase <= {NUM_SYNTH*2*COARSE_W{1'b0}};
        end else begin
            o_fine_phase   <= fine_q[NUM_SYNTH*8-1:0];
            o_coarse_phase <= coarse_cl;
        end
    end

    //--------------------------------------------------------------------
    // axi4-lite read channel
    //--------------------------------------------------------------------
    reg [31:0] rd_mux;
    reg        rd_hit;

    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (i_araddr)
            `REG_FINE_PHASE:   rd_mux = fine_q;
            `REG_COARSE_PHASE: rd_mux = coarse_raw_q;
            `REG_REF_CONFIG:   rd_mux = {23'h00_0000, o_ref_diff};
            `REG_DIV_ENABLE:   rd_mux = {{(32-NUM_SYNTH*4){1'b0}}, o_div_en};
            `REG_MCLK_STATUS: begin
                rd_mux[`MCLK_CODE_LSB +: 2] = o_mclk_sel;
                rd_mux[`MCLK_VALID_BIT]     = o_mclk_valid;
                rd_mux[`MCLK_RSVD_BIT]      = (o_mclk_sel == `STRAP_RSVD);
            end
            `REG_MCLK_TRIM:    rd_mux = trim_q;
            default:           rd_hit = 1'b0;
        endcase
    end

    // one read at a time, answer two edges after arvalid
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= `RESP_OKAY;
        end else begin
            o_arready <= i_arvalid && !o_arready && !o_rvalid;
            if (o_arready && i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_mux;
                o_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

endmodule // skew_strap_ctrl

`default_nettype wire

//--- include/skew_strap_regs.vh
`ifndef SKEW_STRAP_REGS_VH
`define SKEW_STRAP_REGS_VH

// register byte addresses
`define REG_FINE_PHASE      8'h00
`define REG_COARSE_PHASE    8'h04
`define REG_REF_CONFIG      8'h08
`define REG_DIV_ENABLE      8'h0C
`define REG_MCLK_STATUS     8'h10
`define REG_MCLK_TRIM       8'h14

// reset values
`define RST_FINE_PHASE      32'h0000_0000
`define RST_COARSE_PHASE    32'h0000_0000
`define RST_REF_CONFIG      9'h000
`define RST_MCLK_TRIM       32'h046A_AAAB

// status field positions
`define MCLK_CODE_LSB       0
`define MCLK_VALID_BIT      2
`define MCLK_RSVD_BIT       3

// strap codes
`define STRAP_24M576        2'b00
`define STRAP_49M152        2'b01
`define STRAP_20M           2'b10
`define STRAP_RSVD          2'b11

// master clock frequencies in hz
`define MCLK_HZ_24M576      32'h0177_0000
`define MCLK_HZ_49M152      32'h02EE_0000
`define MCLK_HZ_20M         32'h0131_2D00

// strap hold window, 125 ms at 40 mhz
`define CLK_HZ              40000000
`define STRAP_HOLD_MS       125
`define STRAP_HOLD_CYC      ((`STRAP_HOLD_MS * (`CLK_HZ / 1000)))

// axi responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

//--- hw/coarse_clamp.v
`include "skew_strap_regs.vh"
`default_nettype none

// saturates a signed coarse step count into the supported range
module coarse_clamp #(
    parameter IN_W  = 8,
    parameter OUT_W = 6
) (
    input  wire [IN_W-1:0]  i_raw,   // signed requested steps
    output wire [OUT_W-1:0] o_steps  // signed clamped steps
);
    // compare one bit wider than either side so neither bound wraps
    localparam XW = ((IN_W > OUT_W) ? IN_W : OUT_W) + 1;
    localparam signed [XW-1:0] MAXV = {{(XW-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
    localparam signed [XW-1:0] MINV = {{(XW-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};

    wire signed [XW-1:0] raw_s;
    assign raw_s = {{(XW-IN_W){i_raw[IN_W-1]}}, i_raw};

    // clamp beyond range rather than wrap
    assign o_steps = (raw_s > MAXV) ? MAXV[OUT_W-1:0] :
                     (raw_s < MINV) ? MINV[OUT_W-1:0] :
                     raw_s[OUT_W-1:0];
endmodule // coarse_clamp

`default_nettype wire

//--- dv/skew_strap_ctrl_assertions.sv
`include "skew_strap_regs.vh"
`default_nettype none
module skew_strap_ctrl_assertions #(
    parameter NUM_SYNTH = 4,
    parameter COARSE_W  = 6,
    parameter HOLD_CYC  = 8
) (
    input wire logic        i_clk,        // clock
    input wire logic        i_reset_n,    // reset
    input wire logic [1:0]  i_gpio_strap, // strap pins
    input wire logic        i_awvalid,    // aw valid
    input wire logic        o_awready,    // aw ready
    input wire logic        i_wvalid,     // w valid
    input wire logic        o_wready,     // w ready
    input wire logic [1:0]  o_bresp,      // b resp
    input wire logic        o_bvalid,     // b valid
    input wire logic        i_bready,     // b ready
    input wire logic        i_arvalid,    // ar valid
    input wire logic        o_arready,    // ar ready
    input wire logic [31:0] o_rdata,      // r data
    input wire logic        o_rvalid,     // r valid
    input wire logic        i_rready,     // r ready
    input wire logic [8:0]  o_ref_diff,   // ref mode
    input wire logic [1:0]  o_mclk_sel,   // strap code
    input wire logic        o_mclk_valid, // capture done
    input wire logic [31:0] o_mclk_hz     // master freq
);
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// helpers
// ----------------------------------------
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
logic [31:0] cnt_q;
logic [31:0] cnt_d;
logic [31:0] hz_exp;
// edges since release, saturating so a long run never wraps
assign cnt_d = (cnt_q == 32'hFFFF_FFFF) ? cnt_q : cnt_q + 32'h0000_0001;
always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) cnt_q <= 32'h0000_0000;
    else cnt_q <= cnt_d;
end
// expected frequency for the captured code
assign hz_exp = (o_mclk_sel == `STRAP_24M576) ? `MCLK_HZ_24M576 :
                (o_mclk_sel == `STRAP_49M152) ? `MCLK_HZ_49M152 :
                (o_mclk_sel == `STRAP_20M) ? `MCLK_HZ_20M : 32'h0000_0000;
// ----------------------------------------
// properties
// ----------------------------------------
a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write answer late");
a_strap_capture: assert property (cnt_q == 32'h0000_0001 |-> o_mclk_sel == $past(i_gpio_strap))
    else $error("strap not taken at release");
a_strap_held: assert property (cnt_q != 32'h0000_0000 |=> $stable(o_mclk_sel))
    else $error("strap code changed after capture");
a_valid_window: assert property (o_mclk_valid == (cnt_q > HOLD_CYC))
    else $error("capture done flag off window");
a_freq_decode: assert property (cnt_q != 32'h0000_0000 |-> o_mclk_hz == hz_exp)
    else $error("master frequency mismatches code");
a_ref_single: assert property (cnt_q == 32'h0000_0001 |-> o_ref_diff == 9'h000)
    else $error("reference not single ended after reset");
c_valid: cover property (cnt_q == HOLD_CYC + 1 && o_mclk_valid);
c_slverr: cover property (o_bvalid && o_bresp == `RESP_SLVERR);
c_read: cover property (o_rvalid && i_rready);
c_rsvd: cover property (o_mclk_sel == `STRAP_RSVD && o_mclk_valid);
endmodule // skew_strap_ctrl_assertions
bind skew_strap_ctrl skew_strap_ctrl_assertions #(.NUM_SYNTH(NUM_SYNTH), .COARSE_W(COARSE_W),
    .HOLD_CYC(HOLD_CYC)) skew_strap_ctrl_assertions_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_gpio_strap(i_gpio_strap), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_ref_diff(o_ref_diff),
    .o_mclk_sel(o_mclk_sel), .o_mclk_valid(o_mclk_valid), .o_mclk_hz(o_mclk_hz));
`default_nettype wire

//--- dv/strap_board_model.sv
`default_nettype none
module strap_board_model #(
    parameter HOLD_CYC = 8
) (
    input  wire logic       i_clk,     // system clock
    input  wire logic       i_reset_n, // power-on reset
    input  wire logic [1:0] i_code,    // wanted strap
    output wire logic [1:0] o_strap    // gpio 1:0 level
);
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// strap pins
// ----------------------------------------
logic [31:0] cnt_q;
logic [31:0] cnt_d;
assign cnt_d = (cnt_q > HOLD_CYC + 1) ? cnt_q : cnt_q + 32'h0000_0001;
// held through the window, then released; no pull fitted, so show the inverse
assign o_strap = (cnt_q > HOLD_CYC + 1) ? ~i_code : i_code;
always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) cnt_q <= 32'h0000_0000;
    else cnt_q <= cnt_d;
end
endmodule // strap_board_model
`default_nettype wire

//--- dv/skew_strap_ctrl_tb_top.sv
`include "skew_strap_regs.vh"
`default_nettype none
module skew_strap_ctrl_tb_top;
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// signals and instances
// ----------------------------------------
localparam int HOLD = 8;
logic        i_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
logic [7:0]  i_awaddr, i_araddr;
logic [31:0] i_wdata;
logic [3:0]  i_wstrb;
logic [1:0]  code;
logic        lazy;
wire  [1:0]  strap, o_bresp, o_rresp, o_mclk_sel;
wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_mclk_valid;
wire  [31:0] o_rdata, o_fine_phase, o_mclk_hz;
wire  [47:0] o_coarse_phase;
wire  [15:0] o_div_en;
wire  [8:0]  o_ref_diff;
int          mismatches, comparisons;
skew_strap_ctrl #(.HOLD_CYC(HOLD)) skew_strap_ctrl_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_gpio_strap(strap), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_fine_phase(o_fine_phase),
    .o_coarse_phase(o_coarse_phase), .o_div_en(o_div_en), .o_ref_diff(o_ref_diff),
    .o_mclk_sel(o_mclk_sel), .o_mclk_valid(o_mclk_valid), .o_mclk_hz(o_mclk_hz));
strap_board_model #(.HOLD_CYC(HOLD)) strap_board_model_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_code(code), .o_strap(strap));
// ----------------------------------------
// bus and check tasks
// ----------------------------------------
task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
endtask
// valids hold until their own ready; a hang is left to the watchdog
// lazy raises bready/rready only once the answer is seen, so the hold is exercised
task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= !lazy;
    do begin
        @(posedge i_clk);
        if (o_awready === 1'b1) i_awvalid <= 1'b0;
        if (o_wready === 1'b1) i_wvalid <= 1'b0;
        if (o_bvalid === 1'b1 && i_bready !== 1'b1) i_bready <= 1'b1;
    end while (o_bvalid !== 1'b1 || i_bready !== 1'b1);
    r = o_bresp;
    i_bready <= 1'b0;
endtask
task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= !lazy;
    do begin
        @(posedge i_clk);
        if (o_arready === 1'b1) i_arvalid <= 1'b0;
        if (o_rvalid === 1'b1 && i_rready !== 1'b1) i_rready <= 1'b1;
    end while (o_rvalid !== 1'b1 || i_rready !== 1'b1);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
endtask
task automatic do_reset(input logic [1:0] c);
    @(posedge i_clk);
    code <= c;
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
endtask
task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_strap;
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] hz [4];
    hz = '{`MCLK_HZ_24M576, `MCLK_HZ_49M152, `MCLK_HZ_20M, 32'h0000_0000};
    for (int c = 0; c < 4; c++) begin
        do_reset(c[1:0]);
        repeat (HOLD + 4) @(posedge i_clk);
        @(negedge i_clk);
        chk("mclk_sel", c, o_mclk_sel);
        chk("mclk_hz", hz[c], o_mclk_hz);
        chk("mclk_valid", 1, o_mclk_valid);
        axi_rd(`REG_MCLK_STATUS, d, r);
        chk("status", {c == 3, 1'b1, c[1:0]}, d);
    end
    $display("strap test done");
endtask
task automatic t_defaults;
    logic [31:0] d;
    logic [1:0]  r;
    chk("ref_diff", 0, o_ref_diff);
    chk("div_en", 0, o_div_en);
    chk("fine_phase", 0, o_fine_phase);
    chk("coarse_phase", 0, o_coarse_phase);
    axi_rd(`REG_MCLK_TRIM, d, r);
    chk("trim", `RST_MCLK_TRIM, d);
    $display("defaults test done");
endtask
task automatic t_phase;
    logic [1:0] r;
    axi_wr(`REG_FINE_PHASE, 32'h80FF_0100, 4'hF, r);
    axi_wr(`REG_FINE_PHASE, 32'h0000_7700, 4'h2, r);
    axi_wr(`REG_COARSE_PHASE, 32'h8000_00F1, 4'hF, r);
    @(negedge i_clk);
    chk("bresp", `RESP_OKAY, r);
    chk("fine_phase", 32'h80FF_7700, o_fine_phase);
    chk("coarse_phase", {6'h38, 30'h0000_0000, 6'h3F, 6'h01}, o_coarse_phase);
    $display("phase test done");
endtask
task automatic t_refdiv;
    logic [31:0] d;
    logic [1:0]  r;
    lazy = 1'b1;
    axi_wr(`REG_REF_CONFIG, 32'hFFFF_FFFF, 4'hF, r);
    axi_wr(`REG_DIV_ENABLE, 32'h0000_A5C3, 4'hF, r);
    @(negedge i_clk);
    chk("ref_diff", 9'h1FF, o_ref_diff);
    chk("div_en", 16'hA5C3, o_div_en);
    axi_rd(`REG_REF_CONFIG, d, r);
    chk("ref_config", 32'h0000_01FF, d);
    lazy = 1'b0;
    $display("refdiv test done");
endtask
task automatic t_errors;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(`REG_MCLK_STATUS, 32'h0000_0000, 4'hF, r);
    chk("status_bresp", `RESP_SLVERR, r);
    axi_rd(8'h20, d, r);
    chk("unmapped_rresp", `RESP_SLVERR, r);
    chk("unmapped_rdata", 0, d);
    axi_rd(`REG_MCLK_STATUS, d, r);
    chk("status_kept", 32'h0000_000F, d);
    $display("errors test done");
endtask
initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
end
// watchdog: the whole run needs well under a thousand cycles
initial begin
    #(25 * 5000);
    mismatches++;
    close_out;
end
initial begin
    {i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, code} = 54'h0;
    lazy = 1'b0;
    t_strap;
    t_defaults;
    t_phase;
    t_refdiv;
    t_errors;
    close_out;
end
endmodule // skew_strap_ctrl_tb_top
`default_nettype wire
